// ### bsid_pkg.sv
// package: constants, offsets and op codes of the borrow-subtract datapath
package bsid_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned HALF_W = 4;

  // register byte offsets on the bus
  localparam logic [7:0] OFF_WORK  = 8'h00;
  localparam logic [7:0] OFF_MEM   = 8'h04;
  localparam logic [7:0] OFF_FLAGS = 8'h08;
  localparam logic [7:0] OFF_OP    = 8'h0C;

  // flag field positions
  localparam int unsigned FLAG_NIL    = 0;
  localparam int unsigned FLAG_BORROW = 1;
  localparam int unsigned FLAG_HALF   = 2;
  localparam int unsigned FLAG_WRAP   = 3;
  localparam int unsigned FLAG_W      = 4;

  // reset values
  localparam logic [7:0] RST_WORK  = 8'h00;
  localparam logic [7:0] RST_MEM   = 8'h00;
  localparam logic [3:0] RST_FLAGS = 4'h0;

  // bus encodings
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [2:0] {
    OP_NONE    = 3'b000,
    OP_SUBC_AM = 3'b001,
    OP_SUBC_MA = 3'b010,
    OP_SUBC_A  = 3'b011,
    OP_SUBC_M  = 3'b100,
    OP_INC_M   = 3'b101,
    OP_DEC_M   = 3'b110,
    OP_CLR_M   = 3'b111
  } bsid_op_t;

endpackage : bsid_pkg

// ### bsid_alu.sv
// combinational 8-bit add/subtract core with nil, borrow, half and wrap
`timescale 1ns/1ps
module bsid_alu #(
  parameter int unsigned WIDTH = bsid_pkg::DATA_W
) (
  // operands
  input  wire logic [WIDTH-1:0] op_a,
  input  wire logic [WIDTH-1:0] op_b,
  input  wire logic             carry_in,
  input  wire logic             add_mode,
  // result and flags
  output logic      [WIDTH-1:0] result,
  output logic                  nil,
  output logic                  borrow,
  output logic                  half,
  output logic                  wrap
);
  import bsid_pkg::*;

  logic [WIDTH:0]  wide;
  logic [HALF_W:0] low;

  always_comb begin
    if (add_mode) begin
      wide = {1'b0, op_a} + {1'b0, op_b} + {{WIDTH{1'b0}}, carry_in};
      low  = {1'b0, op_a[HALF_W-1:0]} + {1'b0, op_b[HALF_W-1:0]}
             + {{HALF_W{1'b0}}, carry_in};
    end else begin
      wide = {1'b0, op_a} - {1'b0, op_b} - {{WIDTH{1'b0}}, carry_in};
      low  = {1'b0, op_a[HALF_W-1:0]} - {1'b0, op_b[HALF_W-1:0]}
             - {{HALF_W{1'b0}}, carry_in};
    end
    result = wide[WIDTH-1:0];
    nil    = (wide[WIDTH-1:0] == '0);
    // top bit is the carry on add and the borrow on subtract
    borrow = wide[WIDTH];
    half   = low[HALF_W];
    // signed wrap: operand signs as seen by the adder, result sign differs
    if (add_mode)
      wrap = (op_a[WIDTH-1] == op_b[WIDTH-1]) &&
             (wide[WIDTH-1] != op_a[WIDTH-1]);
    else
      wrap = (op_a[WIDTH-1] != op_b[WIDTH-1]) &&
             (wide[WIDTH-1] != op_a[WIDTH-1]);
  end

endmodule : bsid_alu

// ### bsid_top.sv
// top: AHB-Lite register slave around the borrow-subtract/inc/dec datapath
//
// What this block does
// RL1: memory gets memory minus working minus borrow
// RL2: working gets working minus memory minus borrow
// RL3: working register loses only the borrow
// RL4: memory byte loses only the borrow
// RL5: increment adds one to memory byte
// RL6: decrement subtracts one from memory byte
// RL7: clear forces memory byte to zero
// RL8: subtract, inc, dec update all four flags
// RL9: 8-bit data; borrow bit7, half-borrow bit3
`timescale 1ns/1ps
module bsid_top (
  // clock, reset, enable
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        CE,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP
);
  import bsid_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] work;
    logic [DATA_W-1:0] mem;
    logic [FLAG_W-1:0] flags;
    bsid_op_t          last_op;
    logic              ph_valid;
    logic              ph_write;
    logic [7:0]        ph_addr;
    logic [31:0]       rdata;
  } bsid_state_t;

  bsid_state_t s_reg;
  bsid_state_t s_next;

  logic              do_exec;
  bsid_op_t          op_code;
  logic [DATA_W-1:0] alu_a;
  logic [DATA_W-1:0] alu_b;
  logic              alu_cin;
  logic              alu_add;
  logic [DATA_W-1:0] alu_res;
  logic              alu_nil;
  logic              alu_borrow;
  logic              alu_half;
  logic              alu_wrap;
  logic              borrow_now;

  assign borrow_now = s_reg.flags[FLAG_BORROW];
  // an op runs in the data phase of a write to the op register
  assign do_exec = s_reg.ph_valid && s_reg.ph_write &&
                   (s_reg.ph_addr == OFF_OP);
  assign op_code = bsid_op_t'(HWDATA[2:0]);

  // operand steering per operation
  always_comb begin
    alu_a   = s_reg.mem;
    alu_b   = '0;
    alu_cin = borrow_now;
    alu_add = 1'b0;
    case (op_code)
      OP_SUBC_AM: begin
        alu_a = s_reg.work;
        alu_b = s_reg.mem;
      end
      OP_SUBC_MA: begin
        alu_b = s_reg.work;
      end
      OP_SUBC_A: begin
        alu_a = s_reg.work;
      end
      OP_INC_M: begin
        alu_b   = 8'h01;
        alu_cin = 1'b0;
        alu_add = 1'b1;
      end
      OP_DEC_M: begin
        alu_b   = 8'h01;
        alu_cin = 1'b0;
      end
      default: begin
        alu_a = s_reg.mem;
      end
    endcase
  end

  bsid_alu #(
    .WIDTH    (DATA_W)
  ) u_alu (
    .op_a     (alu_a),
    .op_b     (alu_b),
    .carry_in (alu_cin),
    .add_mode (alu_add),
    .result   (alu_res),
    .nil      (alu_nil),
    .borrow   (alu_borrow),
    .half     (alu_half),
    .wrap     (alu_wrap)
  );

  always_comb begin
    s_next = s_reg;
    // a low enable freezes every bit of state, bus phases included
    if (CE) begin
      if (s_reg.ph_valid && s_reg.ph_write) begin
        if (s_reg.ph_addr == OFF_WORK) begin
          s_next.work = HWDATA[DATA_W-1:0];
        end else if (s_reg.ph_addr == OFF_MEM) begin
          s_next.mem = HWDATA[DATA_W-1:0];
        end else if (s_reg.ph_addr == OFF_FLAGS) begin
          s_next.flags = HWDATA[FLAG_W-1:0];
        end else if (s_reg.ph_addr == OFF_OP) begin
          s_next.last_op = op_code;
          case (op_code)
            OP_SUBC_AM, OP_SUBC_A: begin
              s_next.work = alu_res; // RL2 RL3
            end
            OP_SUBC_MA, OP_SUBC_M, OP_INC_M, OP_DEC_M: begin
              s_next.mem = alu_res; // RL1 RL4 RL5 RL6
            end
            OP_CLR_M: begin
              s_next.mem = '0; // RL7
            end
            default: begin
              s_next.mem = s_reg.mem;
            end
          endcase
          if (op_code != OP_NONE && op_code != OP_CLR_M) begin
            s_next.flags[FLAG_NIL]    = alu_nil; // RL8
            s_next.flags[FLAG_BORROW] = alu_borrow; // RL9
            s_next.flags[FLAG_HALF]   = alu_half; // RL9
            s_next.flags[FLAG_WRAP]   = alu_wrap; // RL8
          end
        end
      end
      s_next.ph_valid = HSEL && HREADY && HTRANS[1];
      if (s_next.ph_valid) begin
        s_next.ph_write = HWRITE;
        s_next.ph_addr  = HADDR[7:0];
      end
      // read data comes from the post-write view so write-then-read agrees
      if (s_next.ph_valid && !HWRITE) begin
        if (HADDR[7:0] == OFF_WORK) begin
          s_next.rdata = {24'h000000, s_next.work};
        end else if (HADDR[7:0] == OFF_MEM) begin
          s_next.rdata = {24'h000000, s_next.mem};
        end else if (HADDR[7:0] == OFF_FLAGS) begin
          s_next.rdata = {28'h0000000, s_next.flags};
        end else if (HADDR[7:0] == OFF_OP) begin
          s_next.rdata = {29'h00000000, s_next.last_op};
        end else begin
          s_next.rdata = 32'h00000000;
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      s_reg          <= '0;
      s_reg.work     <= RST_WORK;
      s_reg.mem      <= RST_MEM;
      s_reg.flags    <= RST_FLAGS;
      s_reg.last_op  <= OP_NONE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign HRDATA    = s_reg.rdata;
  // the bus stalls while the block is frozen so no write is dropped
  assign HREADYOUT = CE;
  assign HRESP     = HRESP_OKAY;

  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  sequence s_issue(bsid_op_t code);
    CE && do_exec && (op_code == code);
  endsequence

  sequence s_arith;
    CE && do_exec && (op_code != OP_NONE) && (op_code != OP_CLR_M);
  endsequence

  a_subc_to_mem: assert property ( // RL1
    s_issue(OP_SUBC_MA) |=> s_reg.mem == 8'($past(s_reg.mem)
      - $past(s_reg.work) - {7'h00, $past(borrow_now)}))
    else $error("memory subtract with borrow wrong");

  a_subc_to_work: assert property ( // RL2
    s_issue(OP_SUBC_AM) |=> s_reg.work == 8'($past(s_reg.work)
      - $past(s_reg.mem) - {7'h00, $past(borrow_now)}))
    else $error("working subtract with borrow wrong");

  a_work_borrow_only: assert property ( // RL3
    s_issue(OP_SUBC_A) |=> (s_reg.work == 8'($past(s_reg.work)
      - {7'h00, $past(borrow_now)})) && $stable(s_reg.mem))
    else $error("working borrow-only subtract wrong");

  a_mem_borrow_only: assert property ( // RL4
    s_issue(OP_SUBC_M) |=> (s_reg.mem == 8'($past(s_reg.mem)
      - {7'h00, $past(borrow_now)})) && $stable(s_reg.work))
    else $error("memory borrow-only subtract wrong");

  a_mem_increment: assert property ( // RL5
    s_issue(OP_INC_M) |=> s_reg.mem == 8'($past(s_reg.mem) + 8'h01))
    else $error("memory increment wrong");

  a_mem_decrement: assert property ( // RL6
    s_issue(OP_DEC_M) |=> s_reg.mem == 8'($past(s_reg.mem) - 8'h01))
    else $error("memory decrement wrong");

  a_mem_clear: assert property ( // RL7
    s_issue(OP_CLR_M) |=> (s_reg.mem == 8'h00) && $stable(s_reg.flags))
    else $error("memory clear wrong");

  a_nil_follows: assert property ( // RL8
    s_arith |=> s_reg.flags[FLAG_NIL] ==
      ((s_reg.last_op == OP_SUBC_AM || s_reg.last_op == OP_SUBC_A)
        ? (s_reg.work == 8'h00) : (s_reg.mem == 8'h00)))
    else $error("nil flag does not match result");

  a_borrow_bit7: assert property ( // RL9
    s_issue(OP_SUBC_AM) |=> s_reg.flags[FLAG_BORROW] ==
      ({1'b0, $past(s_reg.work)} <
       ({1'b0, $past(s_reg.mem)} + {8'h00, $past(borrow_now)})))
    else $error("borrow flag wrong");

  a_half_bit3: assert property ( // RL9
    s_issue(OP_DEC_M) |=> s_reg.flags[FLAG_HALF] ==
      ($past(s_reg.mem[3:0]) == 4'h0))
    else $error("half-borrow flag wrong");

  // a frozen block must stall the bus and keep every bit of state
  a_freeze_hold: assert property (
    !CE |-> !HREADYOUT ##1 $stable(s_reg))
    else $error("state moved while enable low");

endmodule : bsid_top

// ### test_borrow_subtract_incdec_alu.sv
// self-checking bench: bus-driven op sequences against a reference model
`timescale 1ns/1ps
module test_borrow_subtract_incdec_alu;
  import bsid_pkg::*;

  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic        ce      = 1'b1;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'b00;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'b010;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  int          errors          = 0;
  int          samples_checked = 0;

  always #10 clk_sys = ~clk_sys;

  bsid_top DUT (
    .CLK_SYS   (clk_sys),
    .RST       (rst),
    .CE        (ce),
    .HSEL      (hsel),
    .HADDR     (haddr),
    .HTRANS    (htrans),
    .HWRITE    (hwrite),
    .HSIZE     (hsize),
    .HWDATA    (hwdata),
    .HREADY    (hreadyout),
    .HRDATA    (hrdata),
    .HREADYOUT (hreadyout),
    .HRESP     (hresp)
  );

  task automatic final_report;
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one single word transfer; entered just after a rising edge
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] v);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    v = hrdata;
    chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask : xfer

  // reference: next work, mem and flags {wrap,half,borrow,nil}
  function automatic void model(input logic [2:0] op,
    input logic [7:0] w, input logic [7:0] m, input logic c,
    input logic [3:0] fi, output logic [7:0] ew,
    output logic [7:0] em, output logic [3:0] ef);
    logic [7:0] a, b, r;
    logic [8:0] f;
    logic [4:0] h;
    logic       ci, wv;
    ew = w;
    em = m;
    ef = fi;
    a  = m;
    b  = 8'h00;
    ci = c;
    if (op == 3'd1 || op == 3'd3) a = w;
    if (op == 3'd1) b = m;
    if (op == 3'd2) b = w;
    if (op == 3'd6) begin
      b  = 8'h01;
      ci = 1'b0;
    end
    if (op == 3'd5) begin
      f  = {1'b0, m} + 9'h001;
      h  = {1'b0, m[3:0]} + 5'h01;
      r  = f[7:0];
      wv = (m == 8'h7F);
    end else begin
      f  = {1'b0, a} - {1'b0, b} - {8'h00, ci};
      h  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
      r  = f[7:0];
      wv = (a[7] != b[7]) && (r[7] != a[7]);
    end
    if (op >= 3'd1 && op <= 3'd6) begin
      ef = {wv, h[4], f[8], r == 8'h00};
      if (op == 3'd1 || op == 3'd3) ew = r;
      else em = r;
    end
    if (op == 3'd7) em = 8'h00;
  endfunction : model

  // {op, work, mem, borrow in}
  localparam logic [19:0] CASES [16] = '{
    {3'd1,8'h00,8'h00,1'b1}, {3'd1,8'h80,8'h01,1'b0},
    {3'd2,8'h01,8'h10,1'b0}, {3'd2,8'h04,8'h05,1'b1},
    {3'd3,8'h00,8'h22,1'b1}, {3'd3,8'h80,8'h22,1'b1},
    {3'd4,8'h11,8'h01,1'b1}, {3'd4,8'h11,8'h10,1'b0},
    {3'd5,8'h00,8'hFF,1'b0}, {3'd5,8'h00,8'h7F,1'b1},
    {3'd5,8'h00,8'h0F,1'b0}, {3'd6,8'h00,8'h00,1'b0},
    {3'd6,8'h00,8'h80,1'b1}, {3'd6,8'h00,8'h01,1'b0},
    {3'd7,8'h3C,8'h5A,1'b1}, {3'd0,8'h33,8'h44,1'b1}};

  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    final_report();
  end

  initial begin
    logic [31:0] v;
    logic [7:0]  ew, em;
    logic [3:0]  fi, ef;
    logic [2:0]  op;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    xfer(OFF_WORK, 1'b0, 32'h0, v);
    chk(v, {24'h0, RST_WORK});
    xfer(OFF_MEM, 1'b0, 32'h0, v);
    chk(v, {24'h0, RST_MEM});
    xfer(OFF_FLAGS, 1'b0, 32'h0, v);
    chk(v, {28'h0, RST_FLAGS});
    xfer(OFF_OP, 1'b0, 32'h0, v);
    chk(v, 32'h0);
    // unmapped offset keeps nothing and reads zero
    xfer(8'h10, 1'b1, 32'hFFFFFFFF, v);
    xfer(8'h10, 1'b0, 32'h0, v);
    chk(v, 32'h0);
    // clock enable low stalls the bus; the write still lands
    ce <= 1'b0;
    fork
      xfer(OFF_WORK, 1'b1, 32'h000000A5, v);
      begin
        repeat (3) @(posedge clk_sys);
        ce <= 1'b1;
      end
    join
    xfer(OFF_WORK, 1'b0, 32'h0, v);
    chk(v, 32'h000000A5);
    foreach (CASES[i]) begin
      op = CASES[i][19:17];
      // stale flags (wrap and nil set, half clear, borrow = borrow in) show whether an op rewrites all four
      fi = {1'b1, 1'b0, CASES[i][0], 1'b1};
      model(op, CASES[i][16:9], CASES[i][8:1], CASES[i][0], fi,
            ew, em, ef);
      xfer(OFF_WORK, 1'b1, {24'h0, CASES[i][16:9]}, v);
      xfer(OFF_MEM, 1'b1, {24'h0, CASES[i][8:1]}, v);
      xfer(OFF_FLAGS, 1'b1, {28'h0, fi}, v);
      xfer(OFF_OP, 1'b1, {29'h0, op}, v);
      xfer(OFF_WORK, 1'b0, 32'h0, v);
      chk(v, {24'h0, ew});
      xfer(OFF_MEM, 1'b0, 32'h0, v);
      chk(v, {24'h0, em});
      xfer(OFF_FLAGS, 1'b0, 32'h0, v);
      chk(v, {28'h0, ef});
      xfer(OFF_OP, 1'b0, 32'h0, v);
      chk(v, {29'h0, op});
    end
    final_report();
  end
endmodule : test_borrow_subtract_incdec_alu
